/* logic/cell_tx_pkg.sv */
package cell_tx_pkg;
   // Interface geometry
   localparam int NUM_PORTS = 4;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 4;
   // Bytes in one cell on the 8-bit bus
   localparam int CELL_BYTES = 53;
   localparam int CNT_W = 6;
   // Reset values of link outputs
   localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   // Link state machine
   typedef enum logic [1:0] {
      LINK_IDLE = 2'b00,
      LINK_SEND = 2'b01
   } link_state_t;
endpackage

/* logic/cell_skid_buf.sv */
`timescale 1ns/1ps
// Two-entry buffer; in_ready stays honest so a stall downstream loses nothing
module cell_skid_buf
   import cell_tx_pkg::*;
#(
   parameter int W = 9
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem_r [2];
   logic [W-1:0] mem_nxt [2];
   logic [1:0] cnt_r, cnt_nxt;
   logic rd_r, rd_nxt, wr_r, wr_nxt;
   logic push, pop;

   ////////////////////////////////////////////////////////////////////////
   assign in_ready = (cnt_r != 2'd2);
   assign out_valid = (cnt_r != 2'd0);
   assign out_data = mem_r[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Next pointers and count
   always_comb begin
      mem_nxt = mem_r;
      if (push) begin
         mem_nxt[wr_r] = in_data;
      end
      wr_nxt = push ? ~wr_r : wr_r;
      rd_nxt = pop ? ~rd_r : rd_r;
      cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= 2'd0;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         mem_r[0] <= '0;
         mem_r[1] <= '0;
      end else begin
         cnt_r <= cnt_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         mem_r <= mem_nxt;
      end
   end
endmodule // cell_skid_buf

/* logic/cell_bus_transmit_port.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Each port sends cells a byte at a time, bit 7 most significant.
// - Each port launches bytes on its own interface clock's rising edge.
// - Start-of-cell high with first byte only, low for the rest.
// - Active-low enable low exactly when the bus holds a valid byte.
// - Four-bit PHY select address per port, bit 3 most significant.
// - Four independent ports, sharing only sys_clk and rst between them.
// - All link signals change and are sampled on the link clock rise.
module cell_bus_transmit_port
   import cell_tx_pkg::*;
(
   // System side
   input wire logic sys_clk,
   input wire logic rst,
   // Cell byte stream per port, sys_clk domain
   input wire logic [NUM_PORTS-1:0] cell_in_valid,
   output logic [NUM_PORTS-1:0] cell_in_ready,
   input wire logic [NUM_PORTS*BYTE_W-1:0] cell_in_byte,
   input wire logic [NUM_PORTS*ADDR_W-1:0] cell_in_phy,
   // Link clocks, one per port
   input wire logic [NUM_PORTS-1:0] cell_bus_clock,
   // Link pins
   output logic [NUM_PORTS*ADDR_W-1:0] tx_phy_select_addr,
   output logic [NUM_PORTS*BYTE_W-1:0] tx_cell_byte,
   output logic [NUM_PORTS*BYTE_W-1:0] tx_cell_byte_oe,
   output logic [NUM_PORTS-1:0] tx_cell_start,
   output logic [NUM_PORTS-1:0] tx_cell_start_oe,
   output logic [NUM_PORTS-1:0] tx_byte_valid_n,
   input wire logic [NUM_PORTS-1:0] tx_phy_cell_room
);
   // Buffer word: the PHY address rides above the byte
   localparam int WW = BYTE_W + ADDR_W;

   // One independent port per generate step, sharing only sys_clk and rst
   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         // sys_clk side: buffer then toggle handshake out to the link
         logic bv, br;
         logic [WW-1:0] bd;
         logic req_r, req_nxt;
         logic [WW-1:0] word_r, word_nxt;
         logic ack_m_r, ack_s_r, ack_nxt0;
         logic busy;
         // link side
         logic lrst_m_r, lrst_r;
         logic lreq_m_r, lreq_s_r, lreq_d_r;
         logic lack_r, lack_nxt;
         link_state_t st_r, st_nxt;
         logic [CNT_W-1:0] cnt_r, cnt_nxt;
         logic room_m_r, room_r;
         logic [WW-1:0] hold_r, hold_nxt;
         logic have_r, have_nxt;
         logic [BYTE_W-1:0] byte_r, byte_nxt;
         logic [ADDR_W-1:0] addr_r, addr_nxt;
         logic soc_r, soc_nxt, enb_n_r, enb_n_nxt, oe_r, oe_nxt;
         logic [ADDR_W-1:0] cell_addr_r, cell_addr_nxt;

         // Two entries, so a stall at the link loses no byte
         cell_skid_buf #(.W(WW)) u_buf (
            .clk(sys_clk),
            .rst(rst),
            .in_valid(cell_in_valid[p]),
            .in_ready(cell_in_ready[p]),
            .in_data({cell_in_phy[p*ADDR_W +: ADDR_W],
                      cell_in_byte[p*BYTE_W +: BYTE_W]}),
            .out_valid(bv),
            .out_ready(br),
            .out_data(bd)
         );

         //////////////////////////////////////////////////////////////////
         // One word in flight while req and synced ack differ
         assign busy = (req_r != ack_s_r);
         assign br = !busy;
         // Toggle req to hand the next word across, one word at a time
         always_comb begin
            req_nxt = req_r;
            word_nxt = word_r;
            if (bv && !busy) begin
               req_nxt = ~req_r;
               word_nxt = bd;
            end
         end
         // Link ack comes back through two sys_clk flops before busy sees it
         assign ack_nxt0 = lack_r;

         // Sys side state; word_r holds still while a toggle is in flight
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               req_r <= 1'b0;
               word_r <= '0;
               ack_m_r <= 1'b0;
               ack_s_r <= 1'b0;
            end else begin
               req_r <= req_nxt;
               word_r <= word_nxt;
               ack_m_r <= ack_nxt0;
               ack_s_r <= ack_m_r;
            end
         end

         //////////////////////////////////////////////////////////////////
         // Reset and handshake resynchronised into the link clock.
         // Link clocks must run during reset, or the link side stays
         // unreset; cell room is a pin and gets the same two flops.
         always_ff @(posedge cell_bus_clock[p]) begin
            lrst_m_r <= rst;
            lrst_r <= lrst_m_r;
            lreq_m_r <= req_r;
            lreq_s_r <= lreq_m_r;
            room_m_r <= tx_phy_cell_room[p];
            room_r <= room_m_r;
         end

         //////////////////////////////////////////////////////////////////
         // Link sequencer; word is stable in word_r while req differs
         always_comb begin
            st_nxt = st_r;
            cnt_nxt = cnt_r;
            hold_nxt = hold_r;
            have_nxt = have_r;
            lack_nxt = lack_r;
            byte_nxt = byte_r;
            addr_nxt = addr_r;
            cell_addr_nxt = cell_addr_r;
            // Strobes default off, so each byte stands one link cycle
            soc_nxt = 1'b0;
            enb_n_nxt = 1'b1;
            oe_nxt = oe_r;
            // Take a crossing word only into an empty hold; the sys side
            // keeps word_r still until the toggled ack gets back to it
            if (!have_r && (lreq_s_r != lreq_d_r)) begin
               hold_nxt = word_r;
               have_nxt = 1'b1;
               lack_nxt = lreq_s_r;
            end
            unique case (st_r)
               LINK_IDLE: begin
                  oe_nxt = 1'b0;
                  // Address goes out as soon as a word waits, ahead of byte 0
                  if (have_r) begin
                     addr_nxt = hold_r[WW-1 -: ADDR_W];
                     cell_addr_nxt = hold_r[WW-1 -: ADDR_W];
                  end
                  // Start only once the addressed PHY shows room
                  if (have_r && room_r) begin
                     st_nxt = LINK_SEND;
                  end
               end
               LINK_SEND: begin
                  oe_nxt = 1'b1;
                  if (have_r) begin
                     byte_nxt = hold_r[BYTE_W-1:0];
                     soc_nxt = (cnt_r == '0);
                     enb_n_nxt = 1'b0;
                     have_nxt = 1'b0;
                     // Byte count closes the cell; no partial cell leaves
                     if (cnt_r == CNT_W'(CELL_BYTES - 1)) begin
                        cnt_nxt = '0;
                        st_nxt = LINK_IDLE;
                     end else begin
                        cnt_nxt = cnt_r + 1'b1;
                     end
                     // Next word is taken on the next edge, so a gap byte follows either way
                     if (lreq_s_r != lreq_d_r) begin
                        have_nxt = 1'b0;
                     end
                  end
                  // Address stays on the cell's PHY until the last byte
                  addr_nxt = cell_addr_r;
               end
               // Unused state codes fall back to idle
               default: st_nxt = LINK_IDLE;
            endcase
         end

         // All sequencer registers clear on the resynchronised reset only
         always_ff @(posedge cell_bus_clock[p]) begin
            if (lrst_r) begin
               st_r <= LINK_IDLE;
               cnt_r <= '0;
               hold_r <= '0;
               have_r <= 1'b0;
               lack_r <= 1'b0;
               lreq_d_r <= 1'b0;
               byte_r <= BYTE_RST;
               addr_r <= ADDR_RST;
               cell_addr_r <= ADDR_RST;
               soc_r <= 1'b0;
               enb_n_r <= 1'b1;
               oe_r <= 1'b0;
            end else begin
               st_r <= st_nxt;
               cnt_r <= cnt_nxt;
               hold_r <= hold_nxt;
               have_r <= have_nxt;
               lack_r <= lack_nxt;
               lreq_d_r <= lack_nxt;
               byte_r <= byte_nxt;
               addr_r <= addr_nxt;
               cell_addr_r <= cell_addr_nxt;
               soc_r <= soc_nxt;
               enb_n_r <= enb_n_nxt;
               oe_r <= oe_nxt;
            end
         end

         //////////////////////////////////////////////////////////////////
         // Pins come straight from link flops; the enables are kept apart
         // so the pad ring builds the 3-state buffers, not this block
         assign tx_phy_select_addr[p*ADDR_W +: ADDR_W] = addr_r;
         assign tx_cell_byte[p*BYTE_W +: BYTE_W] = byte_r;
         assign tx_cell_byte_oe[p*BYTE_W +: BYTE_W] = {BYTE_W{oe_r}};
         assign tx_cell_start[p] = soc_r;
         assign tx_cell_start_oe[p] = oe_r;
         assign tx_byte_valid_n[p] = enb_n_r;
      end
   endgenerate
endmodule // cell_bus_transmit_port

/* tb/cell_tx_monitor.sv */
`timescale 1ns/1ps
// Watches port 0 of the link side; the other ports are judged by the bench
module cell_tx_monitor
   import cell_tx_pkg::*;
(
   // Reset and link clocks
   input wire logic rst,
   input wire logic [NUM_PORTS-1:0] cell_bus_clock,
   // Link pins
   input wire logic [NUM_PORTS*ADDR_W-1:0] tx_phy_select_addr,
   input wire logic [NUM_PORTS*BYTE_W-1:0] tx_cell_byte_oe,
   input wire logic [NUM_PORTS-1:0] tx_cell_start,
   input wire logic [NUM_PORTS-1:0] tx_cell_start_oe,
   input wire logic [NUM_PORTS-1:0] tx_byte_valid_n
);
   default clocking cb @(posedge cell_bus_clock[0]); endclocking
   default disable iff (rst);
   wire sent = !tx_byte_valid_n[0];
   wire first = tx_cell_start[0];
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic oe_d_r;
   ////////////////////////////////////////////////////////////////////////
   // Byte position in the cell; restarts on a start so a lost byte shows
   always_comb begin
      cnt_nxt = cnt_r;
      if (sent) cnt_nxt = first ? 6'h01 : cnt_r + 6'h01;
   end
   always_ff @(posedge cell_bus_clock[0]) cnt_r <= rst ? 6'h00 : cnt_nxt;
   // Drive seen one edge ago; cleared in reset so no false edge follows
   always_ff @(posedge cell_bus_clock[0])
      oe_d_r <= rst ? 1'b0 : tx_cell_start_oe[0];
   ////////////////////////////////////////////////////////////////////////
   // Link rules on port 0
   start_en_a: assert property (first |-> sent)
      else $error("start without enabled byte");
   start_pos_a: assert property (sent && first |-> cnt_r inside {0, 53})
      else $error("start inside a cell");
   mid_pos_a: assert property (sent && !first |-> cnt_r inside {[1:52]})
      else $error("byte outside a cell");
   drive_en_a: assert property (sent |-> &tx_cell_byte_oe[7:0])
      else $error("byte sent while floating");
   oe_pair_a: assert property ({8{tx_cell_start_oe[0]}} ==
      tx_cell_byte_oe[7:0]) else $error("data and start enables differ");
   cell_end_a: assert property (oe_d_r && !tx_cell_start_oe[0] |->
      cnt_r == 53) else $error("bus released mid-cell");
   addr_hold_a: assert property (sent && !first |->
      $stable(tx_phy_select_addr[3:0])) else $error("address moved");
   oe_rise_a: assert property (!oe_d_r && tx_cell_start_oe[0] |->
      first && sent) else $error("drive began without start");
endmodule // cell_tx_monitor
bind cell_bus_transmit_port cell_tx_monitor mon (.*);

/* tb/phy_model.sv */
`timescale 1ns/1ps
// Far-side devices: link clock, cell room and byte capture per port
module phy_model
   import cell_tx_pkg::*;
(
   // Clock and room
   output logic [NUM_PORTS-1:0] link_clk,
   output logic [NUM_PORTS-1:0] room,
   input wire logic [NUM_PORTS-1:0] stall,
   // Link pins
   input wire logic [NUM_PORTS*ADDR_W-1:0] addr,
   input wire logic [NUM_PORTS*BYTE_W-1:0] data,
   input wire logic [NUM_PORTS*BYTE_W-1:0] data_oe,
   input wire logic [NUM_PORTS-1:0] soc,
   input wire logic [NUM_PORTS-1:0] soc_oe,
   input wire logic [NUM_PORTS-1:0] en_n
);
   logic [8:0] mem [NUM_PORTS][CELL_BYTES];
   logic [8:0] seen;
   logic [ADDR_W-1:0] got_addr [NUM_PORTS];
   int n [NUM_PORTS] = '{default: 0};
   int k [NUM_PORTS] = '{default: 0};
   // Runs through reset too; odd offset keeps edges off the system clock
   initial begin
      link_clk = '0;
      room = '0;
      #1.3;
      forever #7.5 link_clk = ~link_clk;
   end
   // Room offered for a whole next cell unless stalled
   always @(posedge link_clk[0]) room <= ~stall;
   // Bytes are taken only on enabled rising edges; a released line reads
   // as the inverse of its last value, so a float shows up as bad data
   always @(posedge link_clk[0]) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         seen = {soc[p], data[8*p+:8]} ^ ~{soc_oe[p], data_oe[8*p+:8]};
         if (en_n[p] === 1'b0) begin
            if (seen[8]) k[p] = 0;
            if (seen[8]) got_addr[p] = addr[4*p+:4];
            if (k[p] < CELL_BYTES) mem[p][k[p]] = seen;
            k[p]++;
            n[p]++;
         end
      end
   end
endmodule // phy_model

/* tb/cell_bus_transmit_port_tb.sv */
`timescale 1ns/1ps
module cell_bus_transmit_port_tb;
   import cell_tx_pkg::*;
`define CHK(w, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
   $display("BAD %s exp %h got %h", w, e, g); end end
   logic sys_clk, rst;
   logic [3:0] cell_in_valid, cell_in_ready, cell_bus_clock, stall;
   logic [3:0] tx_phy_cell_room, tx_cell_start, tx_cell_start_oe;
   logic [3:0] tx_byte_valid_n;
   logic [31:0] cell_in_byte, tx_cell_byte, tx_cell_byte_oe;
   logic [15:0] cell_in_phy, tx_phy_select_addr;
   int errors = 0, n_tests = 0;
   cell_bus_transmit_port DUT (.*);
   phy_model phy (.link_clk(cell_bus_clock), .room(tx_phy_cell_room),
      .stall(stall), .addr(tx_phy_select_addr), .data(tx_cell_byte),
      .data_oe(tx_cell_byte_oe), .soc(tx_cell_start),
      .soc_oe(tx_cell_start_oe), .en_n(tx_byte_valid_n));
   initial begin
      sys_clk = 0;
      forever #4 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task conclude;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Offer one byte and hold it until ready is seen at an edge
   task automatic push(int p, logic [7:0] b, logic [3:0] a);
      int w = 0;
      cell_in_byte[8*p+:8] <= b;
      cell_in_phy[4*p+:4] <= a;
      cell_in_valid[p] <= 1'b1;
      do begin @(negedge sys_clk); w++; end
      while (cell_in_ready[p] !== 1'b1 && w < 5000);
      if (w >= 5000) begin errors++; conclude(); end
      @(posedge sys_clk);
   endtask
   // One cell on port p; with st the far side withholds room first
   task automatic t_cell(int p, logic [7:0] base, logic [3:0] a, bit st);
      int n0 = phy.n[p], w = 0;
      if (st) begin stall[p] <= 1'b1; repeat (10) @(posedge sys_clk); end
      fork
         begin
            for (int i = 0; i < CELL_BYTES; i++) push(p, 8'(base + i), a);
            cell_in_valid[p] <= 1'b0;
         end
      join_none
      if (st) begin
         repeat (300) @(posedge sys_clk);
         @(negedge sys_clk);
         `CHK("full", 1'b0, cell_in_ready[p])
         `CHK("held", n0, phy.n[p])
         @(posedge sys_clk);
         stall[p] <= 1'b0;
      end
      wait fork;
      while (phy.n[p] < n0 + CELL_BYTES && w < 2000) begin
         @(posedge sys_clk);
         w++;
      end
      if (w >= 2000) begin errors++; conclude(); end
      for (int i = 0; i < CELL_BYTES; i++)
         `CHK("byte", {i == 0, 8'(base + i)}, phy.mem[p][i])
      `CHK("addr", a, phy.got_addr[p])
      repeat (10) @(negedge sys_clk);
      `CHK("float", 9'h000, {tx_cell_start_oe[p], tx_cell_byte_oe[8*p+:8]})
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Six cycles; link clocks run through reset so the resync sees it
   initial begin
      rst = 1'b1;
      {cell_in_valid, cell_in_byte, cell_in_phy, stall} = '0;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      `CHK("idle", 4'hf, tx_byte_valid_n)
      @(posedge sys_clk);
      fork
         t_cell(0, 8'h00, 4'h9, 0);
         t_cell(1, 8'h40, 4'h6, 0);
         t_cell(2, 8'h80, 4'ha, 1);
         t_cell(3, 8'hc0, 4'h5, 0);
      join
      @(posedge sys_clk);
      t_cell(0, 8'hf0, 4'h3, 1);
      conclude();
   end
endmodule // cell_bus_transmit_port_tb
